// file: rtl/pwm_ctrl_pkg.sv
// constants, field layout and mode encodings of the fast timer pwm control block
// assumes a single 250 MHz clock domain shared by the register port and the timer
package pwm_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 10;
    localparam int CNT_W = 10;
    localparam int PRE_W = 14;
    localparam int CH_N = 3;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_D = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL_C = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SHAPE = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_MATCH_A = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MATCH_B = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_TOP = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_MATCH_D = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h8;

    // waveform_control_a fields
    localparam int A_MODE_A_LSB = 6;
    localparam int A_MODE_B_LSB = 4;
    localparam int A_FORCE_A = 3;
    localparam int A_FORCE_B = 2;
    localparam int A_PE_A = 1;
    localparam int A_PE_B = 0;
    // clock_deadtime_control fields
    localparam int B_INV = 7;
    localparam int B_RESTART = 6;
    localparam int B_DT_LSB = 4;
    localparam int B_CS_LSB = 0;
    // output_mode_control_c fields
    localparam int C_SHADOW_A_LSB = 6;
    localparam int C_SHADOW_B_LSB = 4;
    localparam int C_MODE_D_LSB = 2;
    localparam int C_FORCE_D = 1;
    localparam int C_PE_D = 0;

    // reset values and fixed counts
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [1:0] DT_DIV8 = 2'h3;
    localparam logic [CNT_W-1:0] RST_MATCH = 10'h000;
    localparam logic [CNT_W-1:0] RST_TOP = 10'h3FF;
    localparam logic [CNT_W-1:0] BOTTOM = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

    typedef enum logic [1:0] {
        OM_PORT = 2'b00,
        OM_TOGGLE = 2'b01,
        OM_CLEAR = 2'b10,
        OM_SET = 2'b11
    } out_mode_t;

    typedef enum logic [1:0] {
        TM_NORMAL = 2'b00,
        TM_FAST = 2'b01,
        TM_DUAL = 2'b11
    } timer_mode_t;
endpackage

// file: rtl/prescale_tick.sv
// power-of-two clock prescaler giving a one-cycle tick every 2**shift cycles
// assumes restart and shift come from flops on the same clock
module prescale_tick
    import pwm_ctrl_pkg::*;
#(
    parameter int W = PRE_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control
    input wire logic restart,
    input wire logic run,
    input wire logic [3:0] shift,
    // tick
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } pre_state_t;

    pre_state_t st_r;
    pre_state_t st_nxt;
    logic [W-1:0] mask;

    // the phase counter runs free so a new shift takes effect without a restart
    assign mask = (W'(1) << shift) - W'(1);
    assign tick = run && ((st_r.cnt & mask) == mask);

    always_comb begin
        st_nxt = st_r;
        if (restart) begin
            st_nxt.cnt = '0;
        end else if (run) begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: rtl/pwm_ctrl.sv
// control logic of a 10-bit fast timer with three pwm compare channels (a, b, d)
// assumes a same-clock register master with one-cycle strobes; single clock source
// Functional notes
// - force on channel a acts only while pulse_enable_a is clear
// - force applies the output-mode action at once, using modes written alongside
// - forcing raises no interrupt; force_match_a always reads zero
// - force_match_b behaves like channel a and reads zero
// - pulse_enable_a set runs channel a as pwm from match_value_a
// - pulse_enable_b set runs channel b as pwm from match_value_b
// - output_inversion inverts true and complementary outputs
// - prescaler_restart resets the prescaler only, self-clears, reads zero
// - dead-time prescaler divides by 1, 2, 4 or 8 per its two bits
// - clock select 0 stops, 1 undivided, each step doubles to 16384
// - bits 7..4 of control c mirror the a and b output modes
// - a nonzero channel d mode connects compare_pin_d over the port
// - complementary d pin connects only in pwm with mode 01
// - channel d mode decodes by pulse_enable_d and the wave shape bit
// - non-pwm d: 00 port, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 01/10 clear on match set at zero; 11 reversed
// - dual slope: 01/10 clear up, set down; 11 reversed
// - enable clear is normal; shape 00 fast, 01 dual slope, top from match c
// - control c bit 0 is pulse_enable_d, bit 1 force_match_d
module pwm_ctrl
    import pwm_ctrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    // channel a pins
    output logic compare_pin_a,
    output logic compare_pin_a_on,
    output logic compare_pin_a_comp,
    output logic compare_pin_a_comp_on,
    // channel b pins
    output logic compare_pin_b,
    output logic compare_pin_b_on,
    output logic compare_pin_b_comp,
    output logic compare_pin_b_comp_on,
    // channel d pins
    output logic compare_pin_d,
    output logic compare_pin_d_on,
    output logic compare_pin_d_comp,
    output logic compare_pin_d_comp_on,
    // dead-time clock enable
    output logic deadtime_tick
);
    typedef struct packed {
        logic [CH_N-1:0][1:0] mode;
        logic [CH_N-1:0] pe;
        logic [CH_N-1:0][CNT_W-1:0] cmp;
        logic [CH_N-1:0] wave;
        logic [CH_N-1:0] pin;
        logic [CH_N-1:0] pin_on;
        logic [CH_N-1:0] comp;
        logic [CH_N-1:0] comp_on;
        logic inv;
        logic restart;
        logic [1:0] dt;
        logic [3:0] cs;
        logic [1:0] ws;
        logic [CNT_W-1:0] top;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic dead_tick;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic tick;
    logic dt_tick;

    function automatic logic act(input logic [1:0] m, input logic w);
        case (m)
            OM_TOGGLE: act = !w;
            OM_CLEAR: act = 1'b0;
            OM_SET: act = 1'b1;
            default: act = w;
        endcase
    endfunction

    // timer prescaler; stopped means no tick, so the count simply holds
    prescale_tick #(.W(PRE_W)) u_timer_pre (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .restart(st_r.restart),
        .run(st_r.cs != CS_STOP),
        .shift(st_r.cs - 4'h1),
        .tick(tick)
    );

    // dead-time prescaler counts the undivided timer clock
    prescale_tick #(.W(4)) u_dead_pre (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .restart(1'b0),
        .run(1'b1),
        .shift({2'b00, st_r.dt}),
        .tick(dt_tick)
    );

    always_comb begin
        logic [CH_N-1:0] force_hit;
        logic [1:0] m;
        logic hit;
        logic dual;
        timer_mode_t tm;
        force_hit = '0;
        m = RST_MODE;
        hit = 1'b0;
        dual = 1'b0;
        tm = TM_NORMAL;
        st_nxt = st_r;
        st_nxt.restart = 1'b0;
        st_nxt.dead_tick = dt_tick;
        if (wr_en) begin
            case (addr)
                OFS_CTRL_A: begin
                    st_nxt.mode[CH_A] = wr_data[A_MODE_A_LSB +: 2];
                    st_nxt.mode[CH_B] = wr_data[A_MODE_B_LSB +: 2];
                    st_nxt.pe[CH_A] = wr_data[A_PE_A];
                    st_nxt.pe[CH_B] = wr_data[A_PE_B];
                    force_hit[CH_A] = wr_data[A_FORCE_A];
                    force_hit[CH_B] = wr_data[A_FORCE_B];
                end
                OFS_CTRL_B: begin
                    st_nxt.inv = wr_data[B_INV];
                    st_nxt.restart = wr_data[B_RESTART];
                    st_nxt.dt = wr_data[B_DT_LSB +: 2];
                    st_nxt.cs = wr_data[B_CS_LSB +: 4];
                end
                OFS_CTRL_C: begin
                    st_nxt.mode[CH_A] = wr_data[C_SHADOW_A_LSB +: 2];
                    st_nxt.mode[CH_B] = wr_data[C_SHADOW_B_LSB +: 2];
                    st_nxt.mode[CH_D] = wr_data[C_MODE_D_LSB +: 2];
                    st_nxt.pe[CH_D] = wr_data[C_PE_D];
                    force_hit[CH_D] = wr_data[C_FORCE_D];
                end
                OFS_SHAPE: st_nxt.ws = wr_data[1:0];
                OFS_MATCH_A: st_nxt.cmp[CH_A] = wr_data;
                OFS_MATCH_B: st_nxt.cmp[CH_B] = wr_data;
                OFS_TOP: st_nxt.top = wr_data;
                OFS_MATCH_D: st_nxt.cmp[CH_D] = wr_data;
                default: ;
            endcase
        end

        // waveform per channel; modes come from st_nxt so same-cycle writes count
        for (int ch = 0; ch < CH_N; ch++) begin
            m = st_nxt.mode[ch];
            hit = tick && (st_r.cnt == st_r.cmp[ch]);
            if (!st_nxt.pe[ch]) begin
                tm = TM_NORMAL;
            end else if (st_r.ws[0]) begin
                tm = TM_DUAL;
            end else begin
                tm = TM_FAST;
            end
            // forcing only touches the waveform; there is no interrupt path at all
            if (force_hit[ch] && !st_nxt.pe[ch]) begin
                st_nxt.wave[ch] = act(m, st_r.wave[ch]);
            end else if (m != OM_PORT) begin
                case (tm)
                    TM_NORMAL: begin
                        if (hit) begin
                            st_nxt.wave[ch] = act(m, st_r.wave[ch]);
                        end
                    end
                    TM_FAST: begin
                        if (hit) begin
                            st_nxt.wave[ch] = (m == OM_SET);
                        end else if (tick && st_r.cnt == BOTTOM) begin
                            st_nxt.wave[ch] = (m != OM_SET);
                        end
                    end
                    TM_DUAL: begin
                        if (hit) begin
                            st_nxt.wave[ch] = (m == OM_SET) ^ st_r.down;
                        end
                    end
                    default: ;
                endcase
            end
            st_nxt.pin[ch] = st_nxt.wave[ch] ^ st_nxt.inv;
            st_nxt.comp[ch] = !st_nxt.wave[ch] ^ st_nxt.inv;
            st_nxt.pin_on[ch] = (m != OM_PORT);
            st_nxt.comp_on[ch] = st_nxt.pe[ch] && (m == OM_TOGGLE);
        end

        // counter: single slope wraps at top, dual slope turns at top and bottom
        dual = (|st_r.pe) && st_r.ws[0];
        if (tick) begin
            if (!dual) begin
                st_nxt.down = 1'b0;
                st_nxt.cnt = (st_r.cnt >= st_r.top) ? BOTTOM : st_r.cnt + CNT_ONE;
            end else if (!st_r.down) begin
                if (st_r.cnt >= st_r.top) begin
                    st_nxt.down = 1'b1;
                    st_nxt.cnt = (st_r.cnt == BOTTOM) ? BOTTOM : st_r.cnt - CNT_ONE;
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_ONE;
                end
            end else if (st_r.cnt == BOTTOM) begin
                st_nxt.down = 1'b0;
                st_nxt.cnt = (st_r.top == BOTTOM) ? BOTTOM : CNT_ONE;
            end else begin
                st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
        end

        // read data stand for exactly one cycle after the strobe
        st_nxt.rdata = '0;
        if (rd_en) begin
            case (addr)
                OFS_CTRL_A: begin
                    st_nxt.rdata = {2'b00, st_r.mode[CH_A], st_r.mode[CH_B], 2'b00,
                                    st_r.pe[CH_A], st_r.pe[CH_B]};
                end
                OFS_CTRL_B: begin
                    st_nxt.rdata = {2'b00, st_r.inv, 1'b0, st_r.dt, st_r.cs};
                end
                OFS_CTRL_C: begin
                    st_nxt.rdata = {2'b00, st_r.mode[CH_A], st_r.mode[CH_B],
                                    st_r.mode[CH_D], 1'b0, st_r.pe[CH_D]};
                end
                OFS_SHAPE: st_nxt.rdata = {8'h00, st_r.ws};
                OFS_MATCH_A: st_nxt.rdata = st_r.cmp[CH_A];
                OFS_MATCH_B: st_nxt.rdata = st_r.cmp[CH_B];
                OFS_TOP: st_nxt.rdata = st_r.top;
                OFS_MATCH_D: st_nxt.rdata = st_r.cmp[CH_D];
                OFS_COUNT: st_nxt.rdata = st_r.cnt;
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.top <= RST_TOP;
            st_r.cmp <= {CH_N{RST_MATCH}};
            st_r.comp <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rdata;
    assign compare_pin_a = st_r.pin[CH_A];
    assign compare_pin_a_on = st_r.pin_on[CH_A];
    assign compare_pin_a_comp = st_r.comp[CH_A];
    assign compare_pin_a_comp_on = st_r.comp_on[CH_A];
    assign compare_pin_b = st_r.pin[CH_B];
    assign compare_pin_b_on = st_r.pin_on[CH_B];
    assign compare_pin_b_comp = st_r.comp[CH_B];
    assign compare_pin_b_comp_on = st_r.comp_on[CH_B];
    assign compare_pin_d = st_r.pin[CH_D];
    assign compare_pin_d_on = st_r.pin_on[CH_D];
    assign compare_pin_d_comp = st_r.comp[CH_D];
    assign compare_pin_d_comp_on = st_r.comp_on[CH_D];
    assign deadtime_tick = st_r.dead_tick;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_force_a_toggle;
        wr_en && addr == OFS_CTRL_A && wr_data[A_FORCE_A] && !wr_data[A_PE_A]
            && wr_data[A_MODE_A_LSB +: 2] == OM_TOGGLE;
    endsequence

    sequence s_dead_div8;
        st_r.dead_tick && st_r.dt == DT_DIV8
            ##1 (st_r.dt == DT_DIV8 && !st_r.dead_tick) [*7];
    endsequence

    sequence s_fast_bottom_d;
        st_r.pe[CH_D] && !st_r.ws[0] && st_r.mode[CH_D] == OM_TOGGLE && tick
            && st_r.cnt == BOTTOM && st_r.cmp[CH_D] != BOTTOM && !wr_en;
    endsequence

    a_force_a_toggles: assert property (s_force_a_toggle |=>
        st_r.wave[CH_A] != $past(st_r.wave[CH_A]))
        else $error("force on channel a did not toggle the waveform");

    a_force_pwm_ignored: assert property (wr_en && addr == OFS_CTRL_A
        && wr_data[A_FORCE_A] && wr_data[A_PE_A] && !tick |=> $stable(st_r.wave[CH_A]))
        else $error("force acted while channel a in pwm mode");

    a_force_a_reads_zero: assert property (rd_en && addr == OFS_CTRL_A |=>
        rd_data[A_FORCE_A] == 1'b0)
        else $error("force_match_a read back nonzero");

    a_force_b_reads_zero: assert property (rd_en && addr == OFS_CTRL_A |=>
        rd_data[A_FORCE_B] == 1'b0)
        else $error("force_match_b read back nonzero");

    a_restart_self_clear: assert property (wr_en && addr == OFS_CTRL_B
        && wr_data[B_RESTART] |=> st_r.restart ##1 !st_r.restart)
        else $error("prescaler restart did not pulse once");

    a_stop_holds_count: assert property (st_r.cs == CS_STOP |=>
        st_r.cnt == $past(st_r.cnt))
        else $error("count moved while timer stopped");

    a_dead_div_eight: assert property (s_dead_div8 |=> st_r.dead_tick)
        else $error("dead-time tick not every eight cycles");

    a_shadow_readback: assert property (rd_en && addr == OFS_CTRL_C |=>
        rd_data[7:4] == $past({st_r.mode[CH_A], st_r.mode[CH_B]}))
        else $error("shadow mode bits differ from control a");

    a_comp_d_gate: assert property (compare_pin_d_comp_on |->
        st_r.pe[CH_D] && st_r.mode[CH_D] == OM_TOGGLE)
        else $error("complementary d pin connected outside pwm mode 01");

    a_fast_bottom_set: assert property (s_fast_bottom_d |=> compare_pin_d == !st_r.inv)
        else $error("fast pwm d not set at bottom");

    a_invert_pins: assert property (compare_pin_a_comp == !compare_pin_a)
        else $error("true and complementary pins not opposite");
endmodule

// file: verification/pin_load.sv
// load model hanging on one compare pin of the timer
// assumes drive and enable come from flops on the bench clock
module pin_load #(
    parameter logic PULL = 1'h0
) (
    // drive from the block
    input wire logic drive,
    input wire logic drive_on,
    // pin direction bit set by software
    input wire logic dir_out,
    // level seen by the load
    output logic level
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin falls to the pull level, never the last driven value
    assign level = (dir_out && drive_on) ? drive : PULL;
endmodule

// file: verification/fast_timer_pwm_control_tb.sv
// self-checking bench for the fast timer pwm control block
// assumes one 250 MHz clock, sync reset, one-cycle register strobes
module fast_timer_pwm_control_tb
    import pwm_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, wr_en, rd_en, dir_out, deadtime_tick;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, v, c0, dlt;
    logic pa, pa_on, pa_c, pa_c_on, pb, pb_on, pb_c, pb_c_on, pd, pd_on, pd_c, pd_c_on;
    wire [2:0] lvl;
    int err_count, n_compared, tick_cnt = 0, s, d[3];
    int hi[3] = '{0, 0, 0};
    logic [1:0] dm[3] = '{2'h1, 2'h2, 2'h3};
    int fexp[3] = '{108, 108, 252};
    logic [1:0] nm[3] = '{2'h3, 2'h2, 2'h1};
    logic nexp[3] = '{1'h1, 1'h0, 1'h1};

    pwm_ctrl i_pwm_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .compare_pin_a(pa), .compare_pin_a_on(pa_on), .compare_pin_a_comp(pa_c),
        .compare_pin_a_comp_on(pa_c_on), .compare_pin_b(pb), .compare_pin_b_on(pb_on),
        .compare_pin_b_comp(pb_c), .compare_pin_b_comp_on(pb_c_on), .compare_pin_d(pd),
        .compare_pin_d_on(pd_on), .compare_pin_d_comp(pd_c), .compare_pin_d_comp_on(pd_c_on),
        .deadtime_tick(deadtime_tick));
    pin_load i_pin_load_a (.drive(pa), .drive_on(pa_on), .dir_out(dir_out), .level(lvl[0]));
    pin_load i_pin_load_b (.drive(pb), .drive_on(pb_on), .dir_out(dir_out), .level(lvl[1]));
    pin_load i_pin_load_d (.drive(pd), .drive_on(pd_on), .dir_out(dir_out), .level(lvl[2]));

    always #2 ref_clk = ~ref_clk;

    // high time and tick counts, sampled mid-cycle where the registered outputs are settled
    always @(negedge ref_clk) begin
        if (deadtime_tick === 1'h1)
            tick_cnt++;
        for (int i = 0; i < 3; i++)
            if (lvl[i] === 1'h1)
                hi[i]++;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= dat;
        wr_en <= 1'h1;
        @(posedge ref_clk);
        wr_en <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dat);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        dat = rd_data;
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string n);
        logic [DATA_W-1:0] r;
        rd(a, r);
        check(n, 16'(r), 16'(exp));
    endtask

    // pins are registered on the write edge itself, together with the written fields
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    // 360 cycles holds a whole number of fast and dual slope periods for top 9
    task automatic measure();
        int st[3];
        st = hi;
        repeat (360) @(posedge ref_clk);
        for (int i = 0; i < 3; i++)
            d[i] = hi[i] - st[i];
    endtask

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        ref_clk = 1'h0;
        sys_rst = 1'h1;
        addr = '0;
        wr_data = '0;
        wr_en = 1'h0;
        rd_en = 1'h0;
        dir_out = 1'h1;
        err_count = 0;
        n_compared = 0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rdc(OFS_CTRL_C, 10'h000, "ctrl_c reset");
        rdc(4'hF, 10'h000, "unmapped");
        wr(OFS_CTRL_A, 10'h048);
        settle();
        check("pin_a force", 16'(lvl[0]), 16'h1);
        check("comp_on_a", 16'(pa_c_on), 16'h0);
        rdc(OFS_CTRL_A, 10'h040, "ctrl_a");
        rdc(OFS_CTRL_C, 10'h040, "shadow a");
        wr(OFS_CTRL_A, 10'h04A);
        settle();
        check("pin_a pwm force", 16'(lvl[0]), 16'h1);
        check("comp_on_a pwm", 16'(pa_c_on), 16'h1);
        wr(OFS_CTRL_A, 10'h034);
        settle();
        check("pin_b force", 16'(lvl[1]), 16'h1);
        check("pin_a_on", 16'(pa_on), 16'h0);
        rdc(OFS_CTRL_A, 10'h030, "ctrl_a b");
        wr(OFS_CTRL_B, 10'h080);
        settle();
        check("pin_a inv", 16'(pa), 16'h0);
        check("comp_a inv", 16'(pa_c), 16'h1);
        check("comp_b inv", 16'(pb_c), 16'h1);
        wr(OFS_CTRL_B, 10'h040);
        rdc(OFS_CTRL_B, 10'h000, "restart");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_C, 10'h032 | 10'(nm[i]) << 2);
            settle();
            check("pin_d force", 16'(lvl[2]), 16'(nexp[i]));
            check("comp_on_d", 16'(pd_c_on), 16'h0);
            check("comp_d", 16'(pd_c), 16'(!nexp[i]));
        end
        wr(OFS_CTRL_C, 10'h030);
        settle();
        check("pin_d_on", 16'(pd_on), 16'h0);
        for (int dt = 0; dt < 4; dt++) begin
            wr(OFS_CTRL_B, 10'(dt << 4));
            repeat (16) @(posedge ref_clk);
            s = tick_cnt;
            repeat (64) @(posedge ref_clk);
            check("deadtime ticks", 16'(tick_cnt - s), 16'(64 >> dt));
        end
        wr(OFS_MATCH_A, 10'h003);
        wr(OFS_MATCH_B, 10'h006);
        wr(OFS_MATCH_D, 10'h003);
        wr(OFS_TOP, 10'h009);
        wr(OFS_SHAPE, 10'h000);
        wr(OFS_CTRL_A, 10'h0B3);
        wr(OFS_CTRL_B, 10'h001);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_C, 10'h0B1 | 10'(dm[i]) << 2);
            repeat (40) @(posedge ref_clk);
            measure();
            check("fast a high", 16'(d[0]), 16'd108);
            check("fast b high", 16'(d[1]), 16'd144);
            check("fast d high", 16'(d[2]), 16'(fexp[i]));
            check("comp_on_d pwm", 16'(pd_c_on), 16'(dm[i] == 2'h1));
            check("comp_on_b pwm", 16'(pb_c_on), 16'h0);
        end
        wr(OFS_SHAPE, 10'h001);
        s = 0;
        for (int i = 1; i < 3; i++) begin
            wr(OFS_CTRL_C, 10'h0B1 | 10'(dm[i]) << 2);
            repeat (40) @(posedge ref_clk);
            measure();
            s += d[2];
            check("dual a high", 16'(d[0]), 16'd120);
            check("dual b high", 16'(d[1]), 16'd120);
            check("dual d high", 16'(d[2]), 16'(i == 1 ? 120 : 240));
        end
        check("dual d sum", 16'(s), 16'd360);
        wr(OFS_CTRL_A, 10'h000);
        wr(OFS_CTRL_C, 10'h000);
        wr(OFS_TOP, 10'h3FF);
        wr(OFS_SHAPE, 10'h000);
        for (int cs = 1; cs < 5; cs++) begin
            wr(OFS_CTRL_B, 10'(cs));
            repeat (8) @(posedge ref_clk);
            rd(OFS_COUNT, c0);
            repeat (62) @(posedge ref_clk);
            rd(OFS_COUNT, v);
            dlt = v - c0;
            check("count rate", 16'(dlt), 16'(64 >> (cs - 1)));
        end
        wr(OFS_CTRL_B, 10'h000);
        rd(OFS_COUNT, c0);
        repeat (20) @(posedge ref_clk);
        rdc(OFS_COUNT, c0, "count held");
        end_of_test();
    end
endmodule
